//--- hw/nvmp_regs.sv
// nvm protection, option and command object registers behind an avalon-mm slave
// assumes: command engine and reset loader on i_ref_clk; mode input stable
`timescale 1ns/10ps
`include "nvmp_cfg.svh"
module nvmp_regs
    import nvmp_pkg::*;
#(
    parameter int CMD_WORDS = 6
) (
    input wire logic i_ref_clk,
    input wire logic i_reset_n,
    input wire logic [4:0] i_avs_address,
    input wire logic i_avs_read,
    input wire logic i_avs_write,
    input wire logic [31:0] i_avs_writedata,
    input wire logic [3:0] i_avs_byteenable,
    output logic [31:0] o_avs_readdata,
    output logic o_avs_waitrequest,
    input wire logic i_special_mode,
    input wire logic i_cfg_load,
    input wire logic [7:0] i_cfg_prot_byte,
    input wire logic i_cfg_prot_dbe,
    input wire logic [7:0] i_cfg_opt_byte,
    input wire logic i_cfg_opt_dbe,
    input wire logic i_cmd_done,
    input wire logic i_res_wr,
    input wire logic [2:0] i_res_index,
    input wire logic [15:0] i_res_data,
    input wire logic [2:0] i_eng_rd_index,
    output logic [15:0] o_eng_rd_data,
    output logic o_cmd_start,
    output logic [7:0] o_cmd_code,
    output logic [23:0] o_cmd_addr,
    output logic [2:0] o_cmd_word_count,
    output logic [6:0] o_clk_div,
    output logic o_cfg_loaded,
    output logic o_eeprom_protect_open,
    output logic [5:0] o_eeprom_protect_size,
    output logic [7:0] o_option_bits
);
    nvmp_state_type state;
    logic pend, take_wr, cmdw_sel, cmd_complete, access_err, pviol, div_loaded, in_ee, ee_protected;
    logic is_pe, is_ee_alter, is_blk_erase, refuse_acc, refuse_viol, launch, mem_wr;
    logic [1:0] mem_wr_be;
    logic [2:0] cmdw_idx, mem_wr_idx, mem_rd_idx;
    logic [15:0] head0, head1, mem_wr_data, mem_rd;
    logic [23:0] tgt_addr, ee_off;
    logic [31:0] rd_mux;

    // ======================================================================
    // bus slave: request, one decode cycle, one answer cycle
    assign take_wr = i_avs_write && !o_avs_waitrequest;
    assign cmdw_sel = (i_avs_address[4:3] == `NVMP_IDX_CMDW_HI) && (i_avs_address[2:0] < 3'(CMD_WORDS));
    assign cmdw_idx = i_avs_address[2:0];
    always_ff @(posedge i_ref_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            pend <= 1'b0;
        end else begin
            pend <= (i_avs_read || i_avs_write) && o_avs_waitrequest && !pend && o_cfg_loaded;
        end
    end

    always_ff @(posedge i_ref_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            o_avs_waitrequest <= 1'b1;
        end else if (pend) begin
            o_avs_waitrequest <= 1'b0;
        end else begin
            o_avs_waitrequest <= 1'b1;
        end
    end

    always_comb begin
        rd_mux = 32'h0000_0000;
        if (cmdw_sel) begin
            rd_mux[15:0] = cmd_complete ? mem_rd : 16'h0000;
        end else begin
            unique case (i_avs_address)
                `NVMP_IDX_CLKDIV: rd_mux[7:0] = {div_loaded, o_clk_div};
                `NVMP_IDX_STATUS: begin
                    rd_mux[`NVMP_BIT_CCF] = cmd_complete;
                    rd_mux[`NVMP_BIT_ACCESS_ERR] = access_err;
                    rd_mux[`NVMP_BIT_PVIOL] = pviol;
                end
                `NVMP_IDX_CMDIDX: rd_mux[2:0] = o_cmd_word_count;
                `NVMP_IDX_EEPROT: rd_mux[7:0] = {o_eeprom_protect_open, 1'b0, o_eeprom_protect_size};
                `NVMP_IDX_OPTION: rd_mux[7:0] = o_option_bits;
                default: rd_mux = 32'h0000_0000;
            endcase
        end
    end
    always_ff @(posedge i_ref_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            o_avs_readdata <= 32'h0000_0000;
        end else if (pend) begin
            o_avs_readdata <= rd_mux;
        end
    end

    // ======================================================================
    // clock divider and word count
    always_ff @(posedge i_ref_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            o_clk_div <= `NVMP_DIV_RESET;
            div_loaded <= 1'b0;
        end else if (take_wr && (i_avs_address == `NVMP_IDX_CLKDIV) && i_avs_byteenable[0]) begin
            o_clk_div <= i_avs_writedata[6:0];
            div_loaded <= 1'b1;
        end
    end

    always_ff @(posedge i_ref_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            o_cmd_word_count <= `NVMP_CMDIDX_RESET;
        end else if (take_wr && (i_avs_address == `NVMP_IDX_CMDIDX) && i_avs_byteenable[0] && cmd_complete) begin
            o_cmd_word_count <= i_avs_writedata[2:0];
        end
    end

    // ======================================================================
    // eeprom protection and option byte, loaded after reset
    always_ff @(posedge i_ref_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            o_cfg_loaded <= 1'b0;
        end else if (i_cfg_load) begin
            o_cfg_loaded <= 1'b1;
        end
    end
    always_ff @(posedge i_ref_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            o_eeprom_protect_open <= 1'(`NVMP_PROT_RESET >> `NVMP_BIT_OPEN);
            o_eeprom_protect_size <= 6'(`NVMP_PROT_RESET);
        end else if (i_cfg_load && !o_cfg_loaded) begin
            if (i_cfg_prot_dbe) begin
                o_eeprom_protect_open <= 1'(`NVMP_PROT_DBE >> `NVMP_BIT_OPEN);
                o_eeprom_protect_size <= 6'(`NVMP_PROT_DBE);
            end else begin
                o_eeprom_protect_open <= i_cfg_prot_byte[`NVMP_BIT_OPEN];
                o_eeprom_protect_size <= i_cfg_prot_byte[5:0];
            end
        end else if (take_wr && (i_avs_address == `NVMP_IDX_EEPROT) && i_avs_byteenable[0]) begin
            if (i_special_mode) begin
                o_eeprom_protect_open <= i_avs_writedata[`NVMP_BIT_OPEN];
                o_eeprom_protect_size <= i_avs_writedata[5:0];
            end else begin
                o_eeprom_protect_open <= o_eeprom_protect_open & i_avs_writedata[`NVMP_BIT_OPEN];
                if (i_avs_writedata[5:0] > o_eeprom_protect_size) begin
                    o_eeprom_protect_size <= i_avs_writedata[5:0];
                end
            end
        end
    end
    always_ff @(posedge i_ref_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            o_option_bits <= `NVMP_OPT_RESET;
        end else if (i_cfg_load && !o_cfg_loaded) begin
            o_option_bits <= i_cfg_opt_dbe ? `NVMP_OPT_DBE : i_cfg_opt_byte;
        end
    end

    // ======================================================================
    // protection check on the launched command
    assign tgt_addr = {head0[7:0], head1};
    assign ee_off = tgt_addr - `NVMP_EE_BASE;
    assign in_ee = (tgt_addr[23:`NVMP_EE_SPAN_BITS] == 13'(`NVMP_EE_BASE >> `NVMP_EE_SPAN_BITS));
    // region end is base + (size+1)*32 - 1
    assign ee_protected = in_ee && !o_eeprom_protect_open
        && (ee_off[`NVMP_EE_SPAN_BITS-1:`NVMP_SECT_BITS] <= o_eeprom_protect_size);
    always_comb begin
        is_pe = 1'b0;
        is_ee_alter = 1'b0;
        is_blk_erase = 1'b0;
        unique case (head0[15:8])
            `NVMP_CMD_PGM_PF, `NVMP_CMD_PGM_ONCE, `NVMP_CMD_ERS_PSECT: is_pe = 1'b1;
            `NVMP_CMD_ERS_ALL: begin
                is_pe = 1'b1;
                is_blk_erase = 1'b1;
            end
            `NVMP_CMD_ERS_BLK: begin
                is_pe = 1'b1;
                is_blk_erase = in_ee;
            end
            `NVMP_CMD_PGM_EE, `NVMP_CMD_ERS_EESECT: begin
                is_pe = 1'b1;
                is_ee_alter = 1'b1;
            end
            default: is_pe = 1'b0;
        endcase
    end
    assign refuse_acc = is_pe && !div_loaded;
    assign refuse_viol = (is_ee_alter && ee_protected) || (is_blk_erase && !o_eeprom_protect_open);

    // ======================================================================
    // command sequencer
    assign launch = take_wr && (i_avs_address == `NVMP_IDX_STATUS) && i_avs_byteenable[0]
        && i_avs_writedata[`NVMP_BIT_CCF] && cmd_complete;
    always_ff @(posedge i_ref_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            state <= ST_IDLE;
            cmd_complete <= 1'b1;
            o_cmd_start <= 1'b0;
        end else begin
            o_cmd_start <= 1'b0;
            unique case (state)
                ST_IDLE: begin
                    if (launch) begin
                        cmd_complete <= 1'b0;
                        state <= ST_CHECK;
                    end
                end
                ST_CHECK: begin
                    if (refuse_acc || refuse_viol) begin
                        cmd_complete <= 1'b1;
                        state <= ST_IDLE;
                    end else begin
                        o_cmd_start <= 1'b1;
                        state <= ST_BUSY;
                    end
                end
                ST_BUSY: begin
                    if (i_cmd_done) begin
                        cmd_complete <= 1'b1;
                        state <= ST_IDLE;
                    end
                end
            endcase
        end
    end
    always_ff @(posedge i_ref_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            o_cmd_code <= 8'h00;
            o_cmd_addr <= 24'h00_0000;
        end else if (state == ST_CHECK) begin
            o_cmd_code <= head0[15:8];
            o_cmd_addr <= tgt_addr;
        end
    end
    // error flags: a hardware set wins over a clear in the same cycle
    always_ff @(posedge i_ref_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            access_err <= 1'b0;
            pviol <= 1'b0;
        end else begin
            if ((state == ST_CHECK) && refuse_acc) begin
                access_err <= 1'b1;
            end else if (take_wr && (i_avs_address == `NVMP_IDX_STATUS) && i_avs_writedata[`NVMP_BIT_ACCESS_ERR]) begin
                access_err <= 1'b0;
            end
            if ((state == ST_CHECK) && !refuse_acc && refuse_viol) begin
                pviol <= 1'b1;
            end else if (take_wr && (i_avs_address == `NVMP_IDX_STATUS) && i_avs_writedata[`NVMP_BIT_PVIOL]) begin
                pviol <= 1'b0;
            end
        end
    end

    // ======================================================================
    // command word array, bus while complete, engine while busy
    always_comb begin
        mem_wr = 1'b0;
        mem_wr_idx = cmdw_idx;
        mem_wr_be = i_avs_byteenable[1:0];
        mem_wr_data = i_avs_writedata[15:0];
        if (state == ST_BUSY) begin
            mem_wr = i_res_wr;
            mem_wr_idx = i_res_index;
            mem_wr_be = 2'h3;
            mem_wr_data = i_res_data;
        end else if (take_wr && cmdw_sel && cmd_complete) begin
            mem_wr = 1'b1;
        end
    end
    assign mem_rd_idx = (state == ST_BUSY) ? i_eng_rd_index : cmdw_idx;
    // copies of the first two words feed the check without a read cycle
    always_ff @(posedge i_ref_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            head0 <= 16'h0000;
            head1 <= 16'h0000;
        end else if (mem_wr) begin
            if (mem_wr_idx == 3'h0) begin
                if (mem_wr_be[0]) head0[7:0] <= mem_wr_data[7:0];
                if (mem_wr_be[1]) head0[15:8] <= mem_wr_data[15:8];
            end
            if (mem_wr_idx == 3'h1) begin
                if (mem_wr_be[0]) head1[7:0] <= mem_wr_data[7:0];
                if (mem_wr_be[1]) head1[15:8] <= mem_wr_data[15:8];
            end
        end
    end
    nvmp_cmd_mem #(
        .WORDS(CMD_WORDS),
        .WIDTH(16)
    ) u_cmd_mem (
        .i_ref_clk(i_ref_clk),
        .i_reset_n(i_reset_n),
        .i_wr_en(mem_wr),
        .i_wr_idx(mem_wr_idx),
        .i_wr_be(mem_wr_be),
        .i_wr_data(mem_wr_data),
        .i_rd_idx(mem_rd_idx),
        .o_rd_data(mem_rd)
    );
    assign o_eng_rd_data = mem_rd;

    // ======================================================================
    // checks
    default clocking cb @(posedge i_ref_clk); endclocking
    default disable iff (!i_reset_n);
    sequence s_prot_wr;
        take_wr && (i_avs_address == `NVMP_IDX_EEPROT) && i_avs_byteenable[0];
    endsequence
    sequence s_check_done;
        (state == ST_CHECK) ##1 (cmd_complete || o_cmd_start);
    endsequence

    a_size_grows: assert property (o_cfg_loaded && !i_special_mode |=> o_eeprom_protect_size >= $past(o_eeprom_protect_size))
        else $error("protection size shrank in normal mode");
    a_open_one_way: assert property (o_cfg_loaded && !i_special_mode && !o_eeprom_protect_open |=> !o_eeprom_protect_open)
        else $error("protection open bit reopened in normal mode");
    a_open_no_prot: assert property ((state == ST_CHECK) && o_eeprom_protect_open && is_ee_alter
        && div_loaded |=> o_cmd_start)
        else $error("open protection still refused a command");
    a_special_free: assert property (s_prot_wr and i_special_mode
        |=> {o_eeprom_protect_open, o_eeprom_protect_size} == {$past(i_avs_writedata[7]), $past(i_avs_writedata[5:0])})
        else $error("special mode protection write not taken");
    a_load_dbe: assert property (i_cfg_load && !o_cfg_loaded && i_cfg_prot_dbe && i_cfg_opt_dbe
        |=> !o_eeprom_protect_open && (o_eeprom_protect_size == 6'h3F) && (o_option_bits == 8'hFF))
        else $error("fault load did not protect all");
    a_load_plain: assert property (i_cfg_load && !o_cfg_loaded && !i_cfg_prot_dbe
        |=> o_eeprom_protect_size == $past(i_cfg_prot_byte[5:0]))
        else $error("protection byte not loaded");
    a_viol_flag: assert property ((state == ST_CHECK) && div_loaded && is_ee_alter && ee_protected
        |=> pviol && cmd_complete && !o_cmd_start)
        else $error("protected eeprom alteration not refused");
    a_div_needed: assert property ((state == ST_CHECK) && is_pe && !div_loaded |=> access_err && !o_cmd_start)
        else $error("command ran without divider");
    a_launch_seq: assert property (launch |=> !cmd_complete ##0 s_check_done)
        else $error("launch sequence broken");
    a_words_locked: assert property (!cmd_complete && !i_res_wr |=> (head0 == $past(head0)) && (head1 == $past(head1)))
        else $error("command words changed while locked");
    a_rsvd_zero: assert property (pend && (i_avs_address == `NVMP_IDX_RSVD) |=> o_avs_readdata == 32'h0000_0000)
        else $error("reserved register read nonzero");
    a_opt_ro: assert property (o_cfg_loaded |=> o_option_bits == $past(o_option_bits))
        else $error("option register changed after load");
endmodule : nvmp_regs

//--- common/nvmp_cfg.svh
// register offsets, field positions, reset values and command codes of the nvm register block
// assumes: included by its bare name by the register block design file
`ifndef NVMP_CFG_SVH
`define NVMP_CFG_SVH

// ======================================================================
// word indices, byte address is four times the index
`define NVMP_IDX_CLKDIV 5'h00
`define NVMP_IDX_STATUS 5'h01
`define NVMP_IDX_CMDIDX 5'h02
`define NVMP_IDX_EEPROT 5'h03
`define NVMP_IDX_OPTION 5'h04
`define NVMP_IDX_RSVD 5'h0B
`define NVMP_IDX_CMDW_HI 2'h2

// ======================================================================
// field positions
`define NVMP_BIT_OPEN 7
`define NVMP_BIT_DIVLD 7
`define NVMP_BIT_CCF 7
`define NVMP_BIT_ACCESS_ERR 5
`define NVMP_BIT_PVIOL 4

// ======================================================================
// reset and fault values
`define NVMP_PROT_RESET 8'h3F
`define NVMP_OPT_RESET 8'hFF
`define NVMP_PROT_DBE 8'h3F
`define NVMP_OPT_DBE 8'hFF
`define NVMP_DIV_RESET 7'h00
`define NVMP_CMDIDX_RESET 3'h0

// ======================================================================
// eeprom window and sector granularity
`define NVMP_EE_BASE 24'h10_0000
`define NVMP_EE_SPAN_BITS 11
`define NVMP_SECT_BITS 5

// ======================================================================
// command codes that alter memory
`define NVMP_CMD_PGM_PF 8'h06
`define NVMP_CMD_PGM_ONCE 8'h07
`define NVMP_CMD_ERS_ALL 8'h08
`define NVMP_CMD_ERS_BLK 8'h09
`define NVMP_CMD_ERS_PSECT 8'h0A
`define NVMP_CMD_PGM_EE 8'h11
`define NVMP_CMD_ERS_EESECT 8'h12

`endif

//--- common/nvmp_pkg.sv
// types shared by the nvm register block
// assumes: nvmp_cfg.svh on the include path
package nvmp_pkg;
    typedef enum logic [1:0] {
        ST_IDLE,
        ST_CHECK,
        ST_BUSY
    } nvmp_state_type;
endpackage : nvmp_pkg

//--- hw/nvmp_cmd_mem.sv
// command word storage with byte lane writes and registered read
// assumes: single writer per cycle, chosen by the caller
`timescale 1ns/10ps
module nvmp_cmd_mem #(
    parameter int WORDS = 6,
    parameter int WIDTH = 16
) (
    input wire logic i_ref_clk,
    input wire logic i_reset_n,
    input wire logic i_wr_en,
    input wire logic [2:0] i_wr_idx,
    input wire logic [1:0] i_wr_be,
    input wire logic [WIDTH-1:0] i_wr_data,
    input wire logic [2:0] i_rd_idx,
    output logic [WIDTH-1:0] o_rd_data
);
    logic [WIDTH-1:0] mem [WORDS];

    // ======================================================================
    // storage, one word per entry
    for (genvar g = 0; g < WORDS; g++) begin : g_word
        always_ff @(posedge i_ref_clk or negedge i_reset_n) begin
            if (!i_reset_n) begin
                mem[g] <= '0;
            end else if (i_wr_en && (i_wr_idx == 3'(g))) begin
                if (i_wr_be[0]) begin
                    mem[g][7:0] <= i_wr_data[7:0];
                end
                if (i_wr_be[1]) begin
                    mem[g][WIDTH-1:8] <= i_wr_data[WIDTH-1:8];
                end
            end
        end
    end

    // ======================================================================
    // registered read
    always_ff @(posedge i_ref_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            o_rd_data <= '0;
        end else if (i_rd_idx < 3'(WORDS)) begin
            o_rd_data <= mem[i_rd_idx];
        end else begin
            o_rd_data <= '0;
        end
    end
endmodule : nvmp_cmd_mem

//--- testbench/tb.sv
// bench for the nvm register block: bus tasks and scripted command sequences
// assumes: nvmp_regs alone, avalon word addressing, bench plays loader and engine
`timescale 1ns/10ps
module tb;
    logic clk, rst_n, rd, wr, smode, load, pdbe, odbe, done, res_wr;
    logic [4:0] addr;
    logic [31:0] wdata, rdata, q, cap;
    logic [3:0] be;
    logic [7:0] pbyte, obyte, cmd_code, optb;
    logic [2:0] res_idx, eng_idx, wcount;
    logic [15:0] res_data, eng_data;
    logic [23:0] cmd_addr;
    logic [6:0] clkdiv;
    logic [5:0] psize;
    logic waitreq, start, loaded, popen;
    int n_fail = 0;
    int n_checks = 0;
    int n_start = 0;

    nvmp_regs i_nvmp_regs (.i_ref_clk(clk), .i_reset_n(rst_n), .i_avs_address(addr), .i_avs_read(rd),
        .i_avs_write(wr), .i_avs_writedata(wdata), .i_avs_byteenable(be), .o_avs_readdata(rdata),
        .o_avs_waitrequest(waitreq), .i_special_mode(smode), .i_cfg_load(load), .i_cfg_prot_byte(pbyte),
        .i_cfg_prot_dbe(pdbe), .i_cfg_opt_byte(obyte), .i_cfg_opt_dbe(odbe), .i_cmd_done(done),
        .i_res_wr(res_wr), .i_res_index(res_idx), .i_res_data(res_data), .i_eng_rd_index(eng_idx),
        .o_eng_rd_data(eng_data), .o_cmd_start(start), .o_cmd_code(cmd_code), .o_cmd_addr(cmd_addr),
        .o_cmd_word_count(wcount), .o_clk_div(clkdiv), .o_cfg_loaded(loaded),
        .o_eeprom_protect_open(popen), .o_eeprom_protect_size(psize), .o_option_bits(optb));

    initial begin
        clk = 0;
        forever #2.5 clk = ~clk;
    end

    // =========================================================
    // engine side: count accepted launches
    always @(posedge clk) begin
        if (start === 1'b1) begin
            n_start <= n_start + 1;
            cap <= {cmd_code, cmd_addr};
        end
    end

    // =========================================================
    // tasks
    task automatic chk(input logic [31:0] s, input logic [31:0] e);
        n_checks++;
        if (s !== e) begin
            n_fail++;
            $display("Error at %0t: seen %h expected %h", $time, s, e);
        end
    endtask : chk

    task automatic test_done();
        $display("checks %0d errors %0d", n_checks, n_fail);
        if (n_fail == 0 && n_checks > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask : test_done

    task automatic xfer(input logic w, input logic [4:0] a, input logic [31:0] d, input logic [3:0] b);
        int n;
        addr <= a;
        wr <= w;
        rd <= !w;
        wdata <= d;
        be <= b;
        n = 0;
        do begin
            @(posedge clk);
            n++;
        end while (waitreq !== 1'b0 && n < 100);
        if (waitreq !== 1'b0) begin
            n_fail++;
            test_done();
        end
        q = rdata;
        rd <= 0;
        wr <= 0;
        @(posedge clk);
    endtask : xfer

    task automatic wrr(input logic [4:0] a, input logic [31:0] d, input logic [3:0] b);
        xfer(1, a, d, b);
    endtask : wrr

    task automatic rdv(input logic [4:0] a, input logic [31:0] e);
        xfer(0, a, 0, 4'hF);
        chk(q, e);
    endtask : rdv

    task automatic do_reset(input logic [7:0] p, input logic pd, input logic [7:0] o, input logic od);
        int n;
        rst_n <= 0;
        pbyte <= p;
        pdbe <= pd;
        obyte <= o;
        odbe <= od;
        repeat (4) @(posedge clk);
        rst_n <= 1;
        @(posedge clk);
        load <= 1;
        @(posedge clk);
        load <= 0;
        n = 0;
        while (loaded !== 1'b1 && n < 20) begin
            @(posedge clk);
            n++;
        end
        if (loaded !== 1'b1) begin
            n_fail++;
            test_done();
        end
    endtask : do_reset

    // status masked to flag and error bits; refused launches get their errors cleared
    task automatic launch(input logic [7:0] c, input logic [23:0] a, input logic [7:0] st);
        wrr(5'h10, {c, a[23:16]}, 4'h3);
        wrr(5'h11, a[15:0], 4'h3);
        wrr(5'h02, 32'h1, 4'h1);
        wrr(5'h01, 32'h80, 4'h1);
        xfer(0, 5'h01, 0, 4'hF);
        chk(q & 32'hB0, {24'h0, st});
        if (st != 0) wrr(5'h01, 32'h30, 4'h1);
    endtask : launch

    task automatic finish_cmd();
        done <= 1;
        @(posedge clk);
        done <= 0;
        @(posedge clk);
        xfer(0, 5'h01, 0, 4'hF);
        chk(q & 32'hB0, 32'h80);
    endtask : finish_cmd

    // =========================================================
    // main sequence
    initial begin
        {rst_n, rd, wr, smode, load, pdbe, odbe, done, res_wr} = '0;
        {addr, wdata, be, pbyte, obyte, res_idx, res_data} = '0;
        eng_idx = 3'h2;
        do_reset(8'h12, 1, 8'h34, 1);
        rdv(5'h03, 32'h3F);
        rdv(5'h04, 32'hFF);
        do_reset(8'h84, 0, 8'hA5, 0);
        rdv(5'h03, 32'h84);
        rdv(5'h04, 32'hA5);
        chk(32'(optb), 32'hA5);
        wrr(5'h03, 32'h83, 4'h1);
        rdv(5'h03, 32'h84);
        wrr(5'h03, 32'h86, 4'h1);
        rdv(5'h03, 32'h86);
        wrr(5'h03, 32'h06, 4'h1);
        rdv(5'h03, 32'h06);
        wrr(5'h03, 32'h86, 4'h1);
        rdv(5'h03, 32'h06);
        chk(32'({popen, 1'b0, psize}), 32'h06);
        wrr(5'h04, 32'h00, 4'h1);
        rdv(5'h04, 32'hA5);
        wrr(5'h0B, 32'hFF, 4'h1);
        rdv(5'h0B, 32'h0);
        rdv(5'h1F, 32'h0);
        wrr(5'h12, 32'h5AC3, 4'h1);
        wrr(5'h12, 32'hA5FF, 4'h2);
        rdv(5'h12, 32'hA5C3);
        for (int i = 3; i < 6; i++) begin
            wrr(5'h10 + 5'(i), 32'h1111 * i, 4'h3);
            rdv(5'h10 + 5'(i), 32'h1111 * i);
        end
        launch(8'h11, 24'h10_0100, 8'hA0);
        wrr(5'h00, 32'h05, 4'h1);
        rdv(5'h00, 32'h85);
        chk(32'(clkdiv), 32'h05);
        launch(8'h11, 24'h10_00C0, 8'h90);
        launch(8'h09, 24'h10_07E0, 8'h90);
        launch(8'h12, 24'h10_0020, 8'h90);
        launch(8'h08, 24'h00_0000, 8'h90);
        chk(n_start, 0);
        launch(8'h11, 24'h10_00E0, 8'h00);
        chk(n_start, 1);
        chk(cap, 32'h1110_00E0);
        wrr(5'h12, 32'h1234, 4'h3);
        wrr(5'h02, 32'h5, 4'h1);
        rdv(5'h12, 32'h0);
        chk(eng_data, 16'hA5C3);
        res_wr <= 1;
        res_idx <= 3'h3;
        res_data <= 16'hBEEF;
        @(posedge clk);
        res_wr <= 0;
        finish_cmd();
        rdv(5'h13, 32'hBEEF);
        rdv(5'h12, 32'hA5C3);
        rdv(5'h02, 32'h1);
        chk(32'(wcount), 32'h1);
        smode <= 1;
        @(posedge clk);
        wrr(5'h03, 32'h02, 4'h1);
        rdv(5'h03, 32'h02);
        wrr(5'h03, 32'h80, 4'h1);
        rdv(5'h03, 32'h80);
        chk(32'({popen, 1'b0, psize}), 32'h80);
        launch(8'h11, 24'h10_0000, 8'h00);
        finish_cmd();
        chk(n_start, 2);
        test_done();
    end
endmodule : tb
